// ### logic/hwcfg_decode.sv
// configuration pin decoder for a single-channel line interface unit
`timescale 1ns/100ps
// Summary of operation
// - hardware mode: receiver power-down pin 0 runs receiver, 1 powers it down
// - hardware mode pattern pins: 00 normal data, 01 all ones, 10 PRBS
// - hardware mode pattern 11 powers the transmitter down instead of sending
// - attenuator select used only in hardware mode; 00 disables attenuator
// - attenuator select 01: receive path, broad bandwidth, 64-bit fifo
// - select 10 receive, 11 transmit path; both narrow bandwidth, 128-bit fifo
// - reset pin low longer than 100 ns resets the device
// - driver enabled while hi-z pin is low, floated while it is high
// - hi-z pin affects only the driver, internal transmit logic keeps running
// - parallel modes use the address/data pins as one muxed bidirectional bus
// - pin control only when both mode select inputs are 00
module hwcfg_decode #(
   parameter int FLUSH_CYC = hwcfg_pkg::JA_FLUSH_CYC_DEF
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // configuration pins
   input wire logic [1:0] modeSelect,
   input wire logic rx_powerdown_pin,
   input wire logic [1:0] tx_pattern_select,
   input wire logic [1:0] jitter_atten_select,
   input wire logic tx_driver_hiz,
   input wire logic hwResetN,
   // settings from the software register file
   input wire logic swRxPowerDown,
   input wire logic [1:0] swTxPattern,
   input wire logic [1:0] swJaSelect,
   // multiplexed address/data pins
   input wire logic [7:0] adIn,
   output logic [7:0] adOut,
   output logic adOeN,
   input wire logic addrStrobe,
   input wire logic readStrobe,
   input wire logic writeStrobe,
   input wire logic [7:0] readData,
   output logic [7:0] busAddr,
   output logic [7:0] busWrData,
   output logic busWrPulse,
   // decoded control mode
   output logic hwControl,
   output logic parallelBus,
   output logic chipReset,
   // receive and transmit controls
   output logic rxPowerDown,
   output logic txAllOnes,
   output logic txPrbs,
   output logic txPowerDown,
   output logic txDriverOeN,
   // jitter attenuator controls
   output logic jaEnable,
   output logic jaInTxPath,
   output logic jaNarrowBw,
   output logic [7:0] jaFifoDepth,
   output logic jaFlush,
   output logic jaPassData
);
   localparam int FLUSH_W = $clog2(FLUSH_CYC + 1);
   localparam logic [FLUSH_W-1:0] FLUSH_LOAD = FLUSH_W'(FLUSH_CYC);
   localparam int RST_CNT_WIDTH = hwcfg_pkg::RST_CNT_W;
   localparam logic [RST_CNT_WIDTH-1:0] RST_CNT_MAX = hwcfg_pkg::RST_CNT_LIMIT;

   hwcfg_sync_if #(.W(hwcfg_pkg::SYNC_W)) syncBus ();

   logic [1:0] modeSync;
   logic rxPdSync;
   logic [1:0] txPatSync;
   logic [1:0] jaSync;
   logic hizSync;
   logic rstNSync;
   logic hwMode;
   logic [1:0] patSel;
   logic [1:0] jaSel;
   logic [1:0] jaCur;
   logic [RST_CNT_WIDTH-1:0] lowCount;
   logic [FLUSH_W-1:0] flushCount;
   hwcfg_pkg::hwcfg_txpat_t txPat;

   // pins are static straps, so two flops of latency costs nothing
   assign syncBus.raw = {hwResetN, tx_driver_hiz, jitter_atten_select, tx_pattern_select,
                         rx_powerdown_pin, modeSelect};

   hwcfg_sync #(
      .W(hwcfg_pkg::SYNC_W),
      .RESET_VAL(hwcfg_pkg::SYNC_W'(1) << hwcfg_pkg::SB_RSTN)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .bus(syncBus.syncer)
   );

   assign modeSync = syncBus.synced[hwcfg_pkg::SB_MODE +: 2];
   assign rxPdSync = syncBus.synced[hwcfg_pkg::SB_RXPD];
   assign txPatSync = syncBus.synced[hwcfg_pkg::SB_TXPAT +: 2];
   assign jaSync = syncBus.synced[hwcfg_pkg::SB_JA +: 2];
   assign hizSync = syncBus.synced[hwcfg_pkg::SB_HIZ];
   assign rstNSync = syncBus.synced[hwcfg_pkg::SB_RSTN];

   assign hwMode = (modeSync == hwcfg_pkg::MODE_HARDWARE);
   assign patSel = hwMode ? txPatSync : swTxPattern;
   // in software mode the pins are tied low anyway; ignoring them guards a bad strap
   assign jaSel = hwMode ? jaSync : swJaSelect;

   // reset pin filter: a single low sample is a glitch, two is longer than the minimum
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lowCount <= '0;
      end else if (!rstNSync) begin
         if (lowCount != RST_CNT_MAX) begin
            lowCount <= lowCount + 1'b1;
         end
      end else begin
         lowCount <= '0;
      end
   end

   // relies on the master clock running while the pin is held low
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         chipReset <= 1'b1;
      end else begin
         chipReset <= !rstNSync && (lowCount >= RST_CNT_MAX);
      end
   end

   // control mode
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hwControl <= 1'b0;
         parallelBus <= 1'b0;
      end else begin
         hwControl <= hwMode;
         parallelBus <= hwcfg_pkg::hwcfg_is_parallel(modeSync);
      end
   end

   // receiver power-down
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rxPowerDown <= 1'b0;
      end else if (chipReset) begin
         rxPowerDown <= 1'b0;
      end else begin
         rxPowerDown <= hwMode ? rxPdSync : swRxPowerDown;
      end
   end

   // transmit pattern
   always_comb begin
      unique case (patSel)
         hwcfg_pkg::PAT_NORMAL: txPat = hwcfg_pkg::TXP_NORMAL;
         hwcfg_pkg::PAT_ALL_ONES: txPat = hwcfg_pkg::TXP_ALL_ONES;
         hwcfg_pkg::PAT_PRBS: txPat = hwcfg_pkg::TXP_PRBS;
         hwcfg_pkg::PAT_POWER_DOWN: txPat = hwcfg_pkg::TXP_POWER_DOWN;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         txAllOnes <= 1'b0;
         txPrbs <= 1'b0;
         txPowerDown <= 1'b0;
      end else if (chipReset) begin
         txAllOnes <= 1'b0;
         txPrbs <= 1'b0;
         txPowerDown <= 1'b0;
      end else begin
         txAllOnes <= (txPat == hwcfg_pkg::TXP_ALL_ONES);
         txPrbs <= (txPat == hwcfg_pkg::TXP_PRBS);
         txPowerDown <= (txPat == hwcfg_pkg::TXP_POWER_DOWN);
      end
   end

   // driver enable: only the output stage floats, so encoder and shaper
   // outputs above are deliberately not gated by the hi-z pin
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         txDriverOeN <= 1'b1;
      end else begin
         txDriverOeN <= hizSync;
      end
   end

   // jitter attenuator selection
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         jaCur <= hwcfg_pkg::JA_SEL_RESET;
      end else if (chipReset) begin
         jaCur <= hwcfg_pkg::JA_SEL_RESET;
      end else begin
         jaCur <= jaSel;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         jaEnable <= 1'b0;
         jaInTxPath <= 1'b0;
         jaNarrowBw <= 1'b0;
         jaFifoDepth <= hwcfg_pkg::JA_DEPTH_NONE;
      end else begin
         unique case (jaCur)
            hwcfg_pkg::JA_OFF: begin
               jaEnable <= 1'b0;
               jaInTxPath <= 1'b0;
               jaNarrowBw <= 1'b0;
               jaFifoDepth <= hwcfg_pkg::JA_DEPTH_NONE;
            end
            hwcfg_pkg::JA_RX_BROAD: begin
               jaEnable <= 1'b1;
               jaInTxPath <= 1'b0;
               jaNarrowBw <= 1'b0;
               jaFifoDepth <= hwcfg_pkg::JA_DEPTH_BROAD;
            end
            hwcfg_pkg::JA_RX_NARROW: begin
               jaEnable <= 1'b1;
               jaInTxPath <= 1'b0;
               jaNarrowBw <= 1'b1;
               jaFifoDepth <= hwcfg_pkg::JA_DEPTH_NARROW;
            end
            hwcfg_pkg::JA_TX_NARROW: begin
               jaEnable <= 1'b1;
               jaInTxPath <= 1'b1;
               jaNarrowBw <= 1'b1;
               jaFifoDepth <= hwcfg_pkg::JA_DEPTH_NARROW;
            end
         endcase
      end
   end

   // flush on any select change; data held off until pointers are recentred
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         jaFlush <= 1'b0;
         flushCount <= '0;
      end else if (jaSel != jaCur && !chipReset) begin
         jaFlush <= 1'b1;
         flushCount <= FLUSH_LOAD;
      end else begin
         jaFlush <= 1'b0;
         if (flushCount != '0) begin
            flushCount <= flushCount - 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         jaPassData <= 1'b0;
      end else begin
         jaPassData <= !chipReset && !jaFlush && (flushCount == '0) && jaEnable;
      end
   end

   // muxed address/data bus: address phase first, then data phase
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busAddr <= 8'h00;
      end else if (parallelBus && addrStrobe) begin
         busAddr <= adIn;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busWrData <= 8'h00;
         busWrPulse <= 1'b0;
      end else begin
         busWrPulse <= parallelBus && writeStrobe && !addrStrobe;
         if (parallelBus && writeStrobe && !addrStrobe) begin
            busWrData <= adIn;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         adOut <= 8'h00;
      end else begin
         adOut <= readData;
      end
   end

   // the pins turn round only in a read data phase
   assign adOeN = !(parallelBus && readStrobe && !addrStrobe);
endmodule : hwcfg_decode

// ### logic/hwcfg_sync.sv
// two-stage synchroniser bank for static configuration pins
`timescale 1ns/100ps
module hwcfg_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // pins in, synchronised levels out
   hwcfg_sync_if.syncer bus
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               stage1[i] <= RESET_VAL[i];
               stage2[i] <= RESET_VAL[i];
            end else begin
               stage1[i] <= bus.raw[i];
               stage2[i] <= stage1[i];
            end
         end
      end
   endgenerate

   assign bus.synced = stage2;
endmodule : hwcfg_sync

// ### shared/hwcfg_pkg.sv
// hardware-mode configuration pin decode: shared constants and types
package hwcfg_pkg;
   // control mode select codes
   localparam logic [1:0] MODE_HARDWARE = 2'h0;
   localparam logic [1:0] MODE_SERIAL = 2'h1;
   localparam logic [1:0] MODE_PAR_DSTRB = 2'h2;
   localparam logic [1:0] MODE_PAR_RDSTRB = 2'h3;

   // transmit pattern codes
   localparam logic [1:0] PAT_NORMAL = 2'h0;
   localparam logic [1:0] PAT_ALL_ONES = 2'h1;
   localparam logic [1:0] PAT_PRBS = 2'h2;
   localparam logic [1:0] PAT_POWER_DOWN = 2'h3;

   // jitter attenuator select codes
   localparam logic [1:0] JA_OFF = 2'h0;
   localparam logic [1:0] JA_RX_BROAD = 2'h1;
   localparam logic [1:0] JA_RX_NARROW = 2'h2;
   localparam logic [1:0] JA_TX_NARROW = 2'h3;

   // attenuator fifo depths in bits
   localparam logic [7:0] JA_DEPTH_BROAD = 8'h40;
   localparam logic [7:0] JA_DEPTH_NARROW = 8'h80;
   localparam logic [7:0] JA_DEPTH_NONE = 8'h00;

   // cycles the attenuator is held off while it flushes and recentres
   localparam int JA_FLUSH_CYC_DEF = 4;

   // positions in the synchronised pin vector
   localparam int SYNC_W = 9;
   localparam int SB_MODE = 0;
   localparam int SB_RXPD = 2;
   localparam int SB_TXPAT = 3;
   localparam int SB_JA = 5;
   localparam int SB_HIZ = 7;
   localparam int SB_RSTN = 8;

   // reset pin filter timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int RST_MIN_NS = 100;
   localparam int RST_MIN_CYC_RAW = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_MIN_CYC = (RST_MIN_CYC_RAW < 1) ? 1 : RST_MIN_CYC_RAW;
   localparam int RST_CNT_W = $clog2(RST_MIN_CYC + 2);
   localparam logic [RST_CNT_W-1:0] RST_CNT_LIMIT = RST_CNT_W'(RST_MIN_CYC);

   // reset values
   localparam logic [1:0] JA_SEL_RESET = JA_OFF;

   typedef enum logic [1:0] {TXP_NORMAL, TXP_ALL_ONES, TXP_PRBS, TXP_POWER_DOWN} hwcfg_txpat_t;

   function automatic logic hwcfg_is_parallel(input logic [1:0] mode);
      hwcfg_is_parallel = (mode == MODE_PAR_DSTRB) || (mode == MODE_PAR_RDSTRB);
   endfunction : hwcfg_is_parallel
endpackage : hwcfg_pkg

// ### shared/hwcfg_sync_if.sv
// carrier between the pin decoder and its synchroniser bank
`timescale 1ns/100ps
interface hwcfg_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport user (output raw, input synced);
   modport syncer (input raw, output synced);
endinterface : hwcfg_sync_if

// ### test/hwcfg_board.sv
// board-side model that straps the configuration pins
`timescale 1ns/100ps
module hwcfg_board (
   // clock and requests from the bench
   input wire logic ref_clk,
   input wire logic [1:0] wantMode,
   input wire logic [5:0] wantCfg,
   input wire logic resetGo,
   input wire logic [3:0] resetLen,
   // configuration pins
   output logic [1:0] modeSelect,
   output logic rx_powerdown_pin,
   output logic [1:0] tx_pattern_select,
   output logic [1:0] jitter_atten_select,
   output logic tx_driver_hiz,
   output logic hwResetN
);
   logic [3:0] lowCnt;
   initial begin
      lowCnt = 4'h0;
      {modeSelect, rx_powerdown_pin, tx_pattern_select, jitter_atten_select, tx_driver_hiz} = 8'h00;
      hwResetN = 1'b1;
   end
   always @(posedge ref_clk) begin
      modeSelect <= wantMode;
      {tx_driver_hiz, tx_pattern_select, rx_powerdown_pin} <= {wantCfg[5], wantCfg[2:0]};
      // under software control the attenuator straps stay grounded
      jitter_atten_select <= (wantMode == 2'h0) ? wantCfg[4:3] : 2'h0;
      lowCnt <= resetGo ? resetLen : lowCnt - {3'h0, lowCnt != 4'h0};
      hwResetN <= !(resetGo || lowCnt > 4'h1);
   end
endmodule : hwcfg_board

// ### test/hwcfg_decode_asserts.sv
// concurrent checks on the configuration pin decoder ports
`timescale 1ns/100ps
module hwcfg_decode_asserts #(parameter int FLUSH_CYC = 4) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // pins
   input wire logic [1:0] modeSelect,
   input wire logic rx_powerdown_pin,
   input wire logic [1:0] tx_pattern_select,
   input wire logic [1:0] jitter_atten_select,
   input wire logic tx_driver_hiz,
   input wire logic hwResetN,
   input wire logic [7:0] adIn,
   input wire logic addrStrobe,
   input wire logic readStrobe,
   // decoded outputs
   input wire logic hwControl,
   input wire logic parallelBus,
   input wire logic chipReset,
   input wire logic rxPowerDown,
   input wire logic txAllOnes,
   input wire logic txPrbs,
   input wire logic txPowerDown,
   input wire logic txDriverOeN,
   input wire logic jaEnable,
   input wire logic jaInTxPath,
   input wire logic jaNarrowBw,
   input wire logic [7:0] jaFifoDepth,
   input wire logic jaFlush,
   input wire logic jaPassData,
   input wire logic [7:0] busAddr,
   input wire logic adOeN
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // decode lags the pins, so checks wait for a history free of reset
   logic [2:0] run;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run <= 3'h0;
      end else begin
         run <= chipReset ? 3'h0 : run + {2'h0, run != 3'h7};
      end
   end
   a_mode_decode: assert property (run == 3'h7 |-> hwControl == ($past(modeSelect, 3) == 2'h0))
      else $error("hardware mode flag wrong");
   a_rx_powerdown: assert property (run == 3'h7 && hwControl |-> rxPowerDown == $past(rx_powerdown_pin, 3))
      else $error("receiver power-down wrong");
   a_tx_pattern: assert property (run == 3'h7 && hwControl
      |-> {1'b0, txPowerDown, txPrbs, txAllOnes} == (4'h1 << $past(tx_pattern_select, 3)) >> 1)
      else $error("transmit pattern decode wrong");
   a_hiz_driver: assert property (run == 3'h7 && hwControl |-> txDriverOeN == $past(tx_driver_hiz, 3))
      else $error("driver enable wrong");
   a_ja_mode: assert property (run == 3'h7 && hwControl && $past(hwControl)
      |-> {jaEnable, jaNarrowBw, jaInTxPath} == {$past(jitter_atten_select, 4) != 2'h0,
      $past(jitter_atten_select[1], 4), $past(jitter_atten_select, 4) == 2'h3}) else $error("attenuator mode wrong");
   a_ja_depth: assert property (run == 3'h7 && hwControl && $past(hwControl) && jaEnable
      |-> jaFifoDepth == ($past(jitter_atten_select[1], 4) ? 8'h80 : 8'h40)) else $error("fifo depth wrong");
   a_ja_flush: assert property (FLUSH_CYC >= 3 && jaFlush |=> !jaPassData [*3])
      else $error("data passed during flush");
   a_reset_long: assert property ($fell(hwResetN) ##1 !hwResetN |-> ##[1:4] chipReset)
      else $error("reset pin ignored");
   a_reset_short: assert property ((!chipReset && hwResetN) ##1 !hwResetN ##1 hwResetN |=> !chipReset [*4])
      else $error("short reset pulse taken");
   a_bus_addr: assert property (parallelBus && addrStrobe |=> busAddr == $past(adIn))
      else $error("address phase not latched");
   a_bus_read: assert property (parallelBus && readStrobe && !addrStrobe |-> !adOeN)
      else $error("read data not driven");
endmodule : hwcfg_decode_asserts
bind hwcfg_decode hwcfg_decode_asserts #(.FLUSH_CYC(FLUSH_CYC)) u_chk (
   .ref_clk(ref_clk),
   .rst(rst),
   .modeSelect(modeSelect),
   .rx_powerdown_pin(rx_powerdown_pin),
   .tx_pattern_select(tx_pattern_select),
   .jitter_atten_select(jitter_atten_select),
   .tx_driver_hiz(tx_driver_hiz),
   .hwResetN(hwResetN),
   .adIn(adIn),
   .addrStrobe(addrStrobe),
   .readStrobe(readStrobe),
   .hwControl(hwControl),
   .parallelBus(parallelBus),
   .chipReset(chipReset),
   .rxPowerDown(rxPowerDown),
   .txAllOnes(txAllOnes),
   .txPrbs(txPrbs),
   .txPowerDown(txPowerDown),
   .txDriverOeN(txDriverOeN),
   .jaEnable(jaEnable),
   .jaInTxPath(jaInTxPath),
   .jaNarrowBw(jaNarrowBw),
   .jaFifoDepth(jaFifoDepth),
   .jaFlush(jaFlush),
   .jaPassData(jaPassData),
   .busAddr(busAddr),
   .adOeN(adOeN)
);

// ### test/hwcfg_decode_tb_top.sv
// self-checking bench for the configuration pin decoder
`timescale 1ns/100ps
module hwcfg_decode_tb_top;
   logic ref_clk, rst, rx_powerdown_pin, tx_driver_hiz, hwResetN, swRxPowerDown, resetGo;
   logic addrStrobe, readStrobe, writeStrobe, adOeN, busWrPulse, hwControl, parallelBus, chipReset;
   logic rxPowerDown, txAllOnes, txPrbs, txPowerDown, txDriverOeN, jaEnable, jaInTxPath, jaNarrowBw;
   logic jaFlush, jaPassData;
   logic [1:0] modeSelect, tx_pattern_select, jitter_atten_select, swTxPattern, swJaSelect, wantMode, lastJa;
   logic [7:0] adIn, readData, adOut, busAddr, busWrData, jaFifoDepth, addr;
   logic [5:0] wantCfg, cfg;
   logic [3:0] resetLen;
   integer seed = 92, errTotal = 0, testsRun = 0, hits;
   hwcfg_board u_board (.*);
   hwcfg_decode #(.FLUSH_CYC(4)) u_dut (.*);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      testsRun++;
      if (got !== exp) begin
         errTotal++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks=%0d errors=%0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim
   // expected {rx pd, tx pd, prbs, ones, driver off, ja on, narrow, tx path}
   function automatic logic [7:0] exp_vec(input logic [5:0] c);
      exp_vec = {c[0], 3'((4'h1 << c[2:1]) >> 1), c[5], c[4:3] != 2'h0, c[4], c[4:3] == 2'h3};
   endfunction : exp_vec
   function automatic logic [7:0] exp_depth(input logic [1:0] j);
      exp_depth = (j == 2'h0) ? 8'h00 : (j == 2'h1) ? 8'h40 : 8'h80;
   endfunction : exp_depth
   task automatic settle();
      hits = 0;
      repeat (14) @(negedge ref_clk) hits += jaFlush;
   endtask : settle
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      #(3000 * 100);
      errTotal++;
      end_sim();
   end
   initial begin
      {rst, swRxPowerDown, resetGo, addrStrobe, readStrobe, writeStrobe} = 6'h20;
      {wantMode, swTxPattern, swJaSelect, lastJa} = 8'h00;
      {adIn, readData, wantCfg, resetLen} = 26'h0000001;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      for (int i = 0; i < 16; i++) begin
         cfg = 6'($random(seed));
         cfg[4:1] = 4'(i);
         @(posedge ref_clk);
         wantCfg <= cfg;
         settle();
         chk(8'(hits), 8'(cfg[4:3] != lastJa));
         chk({rxPowerDown, txPowerDown, txPrbs, txAllOnes, txDriverOeN, jaEnable, jaNarrowBw, jaInTxPath},
            exp_vec(cfg));
         chk(jaFifoDepth, exp_depth(cfg[4:3]));
         chk(8'({hwControl, jaPassData}), 8'({1'b1, cfg[4:3] != 2'h0}));
         lastJa = cfg[4:3];
      end
      // pins and software settings disagree, so the source shows
      cfg = 6'($random(seed));
      @(posedge ref_clk);
      wantMode <= 2'h1;
      wantCfg <= cfg;
      swRxPowerDown <= ~cfg[0];
      swTxPattern <= ~cfg[2:1];
      swJaSelect <= 2'h1;
      settle();
      chk(8'({hwControl, rxPowerDown, txPowerDown, txPrbs, txAllOnes}),
         exp_vec({cfg[5:3], ~cfg[2:0]}) >> 4);
      chk(jaFifoDepth, exp_depth(2'h1));
      for (int l = 1; l < 4; l += 2) begin
         @(posedge ref_clk);
         resetGo <= 1'b1;
         resetLen <= 4'(l);
         @(posedge ref_clk);
         resetGo <= 1'b0;
         hits = 0;
         repeat (10) @(negedge ref_clk) hits += chipReset;
         chk(8'(hits != 0), 8'(l > 1));
      end
      for (int m = 2; m < 4; m++) begin
         addr = 8'($random(seed));
         @(posedge ref_clk);
         wantMode <= 2'(m);
         repeat (8) @(posedge ref_clk);
         addrStrobe <= 1'b1;
         adIn <= addr;
         @(posedge ref_clk);
         addrStrobe <= 1'b0;
         readStrobe <= 1'b1;
         readData <= ~addr;
         @(negedge ref_clk);
         chk(8'({adOeN, parallelBus}), 8'h01);
         chk(busAddr, addr);
         @(posedge ref_clk);
         readStrobe <= 1'b0;
         writeStrobe <= 1'b1;
         adIn <= addr ^ 8'h3c;
         @(negedge ref_clk);
         chk(adOut, ~addr);
         @(posedge ref_clk);
         writeStrobe <= 1'b0;
         @(negedge ref_clk);
         chk(8'({adOeN, busWrPulse}), 8'h03);
         chk(busWrData, addr ^ 8'h3c);
      end
      end_sim();
   end
endmodule : hwcfg_decode_tb_top
